// *** hdl/osrg_regs.svh ***
`ifndef OSRG_REGS_SVH
`define OSRG_REGS_SVH

// ==========================================================
// Register selectors for the read mux
`define OSRG_SEL_LIVE      2'h0
`define OSRG_SEL_EVENTS    2'h1
`define OSRG_SEL_MASK      2'h2

// ==========================================================
// Bit positions shared by all three registers
`define OSRG_BIT_ERROR     13
`define OSRG_BIT_CLOSED    11
`define OSRG_BIT_REMOTE    10
`define OSRG_BIT_AWAIT_TRG 5
`define OSRG_BIT_SCANNING  4

// Bits that carry a condition
`define OSRG_USED_MASK     16'h2c30
`define OSRG_MASK_RESET    16'h0000
`define OSRG_EVENTS_RESET  16'h0000
`define OSRG_READ_RESET    16'h0000
`define OSRG_SUMMARY_RESET 1'b0

`endif

// *** hdl/osrg_pkg.sv ***
package osrg_pkg;
    typedef logic [15:0] osrg_word_t;
    typedef logic [1:0]  osrg_sel_t;
endpackage

// *** hdl/osrg_top.sv ***
`timescale 1ns/100ps
`include "osrg_regs.svh"
// Contract
// - Live-state read returns present conditions, nothing latched.
// - Unassigned bits read zero in live and event registers.
// - Error 13, closed 11, remote 10, awaiting trigger 5, scanning 4.
// - Only remote active reads as 1024 in live and event registers.
// - Event read returns retained record of past conditions.
// - Mask is written by set command and read by query.
// - Mask is zero after power-up.
// - Unassigned mask bits read zero whatever was written.
module osrg_top (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,

    // Live conditions
    input  wire logic                 error_in,
    input  wire logic                 relay_closed_in,
    input  wire logic                 remote_state_in,
    input  wire logic                 awaiting_trigger_flag_in,
    input  wire logic                 scanning_in,

    // Command port
    input  wire logic                 clear_status_in,
    input  wire logic                 mask_write_in,
    input  wire osrg_pkg::osrg_word_t mask_wdata_in,
    // Select: 0 live, 1 events, 2 mask, 3 spare
    input  wire osrg_pkg::osrg_sel_t  read_sel_in,

    // Answers
    output osrg_pkg::osrg_word_t      read_data_out,
    output logic                      summary_out
);
    import osrg_pkg::*;

    // ==========================================================
    // Helper functions

    // Places the five condition levels at their shared bit positions.
    // Every other position stays zero, so no stray bit can leak out.
    function automatic osrg_word_t pack_conditions(
        input logic err_lvl,
        input logic closed_lvl,
        input logic remote_lvl,
        input logic await_lvl,
        input logic scan_lvl
    );
        osrg_word_t word;

        word                      = 16'h0000;
        word[`OSRG_BIT_ERROR]     = err_lvl;
        word[`OSRG_BIT_CLOSED]    = closed_lvl;
        word[`OSRG_BIT_REMOTE]    = remote_lvl;
        word[`OSRG_BIT_AWAIT_TRG] = await_lvl;
        word[`OSRG_BIT_SCANNING]  = scan_lvl;
        return word;
    endfunction

    // Clears the positions that carry no condition
    // Used by every path that shows a register, so the rule lives once
    function automatic osrg_word_t keep_used_bits(input osrg_word_t word);
        return word & `OSRG_USED_MASK;
    endfunction

    // High when some bit is set in both words
    function automatic logic any_enabled(
        input osrg_word_t events,
        input osrg_word_t mask
    );
        return |(events & mask);
    endfunction

    // ==========================================================
    // Registers and their next values

    // Each stored register has its own next-value process and its own flop

    // Live conditions, not stored
    osrg_word_t live_word;

    // Event record
    osrg_word_t operation_latched_events_ff;
    osrg_word_t nxt_operation_latched_events;

    // Enable mask
    osrg_word_t operation_event_mask_ff;
    osrg_word_t nxt_operation_event_mask;

    // Query answer
    osrg_word_t read_data_ff;
    osrg_word_t nxt_read_data;

    // Summary toward the status byte
    logic       summary_ff;
    logic       nxt_summary;

    // ==========================================================
    // Live condition word

    // Remote alone gives 1024
    // Not stored: a query must see each level as it is now
    always_comb begin
        live_word = pack_conditions(error_in,
                                    relay_closed_in,
                                    remote_state_in,
                                    awaiting_trigger_flag_in,
                                    scanning_in);
    end

    // ==========================================================
    // Event latch

    // Inputs are sampled once per clock, so a condition that rises and
    // falls between two edges is never recorded.

    // Set wins over clear
    // A condition still live at the clear is kept, never lost for a cycle.
    always_comb begin
        if (clear_status_in) begin
            nxt_operation_latched_events = live_word;
        end else begin
            nxt_operation_latched_events =
                operation_latched_events_ff | live_word;
        end
    end

    // Retained record
    // Reset empties the record as power-up does
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            operation_latched_events_ff <= `OSRG_EVENTS_RESET;
        end else begin
            operation_latched_events_ff <= nxt_operation_latched_events;
        end
    end

    // ==========================================================
    // Enable mask

    // Unused bits dropped
    // Dropping them at the write keeps the query and the summary in step.
    always_comb begin
        if (mask_write_in) begin
            nxt_operation_event_mask = keep_used_bits(mask_wdata_in);
        end else begin
            nxt_operation_event_mask = operation_event_mask_ff;
        end
    end

    // Zero at power-up
    // Mask keeps its value until the next set command
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            operation_event_mask_ff <= `OSRG_MASK_RESET;
        end else begin
            operation_event_mask_ff <= nxt_operation_event_mask;
        end
    end

    // ==========================================================
    // Query answer

    // Registered: the answer shows one edge after the select is taken
    always_comb begin
        case (read_sel_in)
            `OSRG_SEL_LIVE: begin
                nxt_read_data = keep_used_bits(live_word);
            end
            `OSRG_SEL_EVENTS: begin
                nxt_read_data = keep_used_bits(operation_latched_events_ff);
            end
            `OSRG_SEL_MASK: begin
                nxt_read_data = keep_used_bits(operation_event_mask_ff);
            end
            // Spare select reads zero
            default: begin
                nxt_read_data = `OSRG_READ_RESET;
            end
        endcase
    end

    // Reset shows zero until the first clock edge after reset loads the selected register
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            read_data_ff <= `OSRG_READ_RESET;
        end else begin
            read_data_ff <= nxt_read_data;
        end
    end

    // ==========================================================
    // Summary toward the status byte

    // Enabled event present
    // Uses the stored record, not live levels, so it holds after a drop
    always_comb begin
        nxt_summary = any_enabled(operation_latched_events_ff,
                                  operation_event_mask_ff);
    end

    // Lags the event record and mask by one edge
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            summary_ff <= `OSRG_SUMMARY_RESET;
        end else begin
            summary_ff <= nxt_summary;
        end
    end

    // ==========================================================
    // Outputs

    // Both answers leave straight from flip-flops
    assign read_data_out = read_data_ff;
    assign summary_out   = summary_ff;
endmodule // osrg_top

// *** bench/osrg_assertions.sv ***
`timescale 1ns/100ps
module osrg_assertions
    import osrg_pkg::*;
(
    // Clock and reset
    input wire logic                 mclk_in,
    input wire logic                 reset_in,
    // Live conditions
    input wire logic                 error_in,
    input wire logic                 relay_closed_in,
    input wire logic                 remote_state_in,
    input wire logic                 awaiting_trigger_flag_in,
    input wire logic                 scanning_in,
    // Command port
    input wire logic                 clear_status_in,
    input wire logic                 mask_write_in,
    input wire osrg_pkg::osrg_word_t mask_wdata_in,
    input wire osrg_pkg::osrg_sel_t  read_sel_in,
    // Answers
    input wire osrg_pkg::osrg_word_t read_data_out,
    input wire logic                 summary_out
);
    osrg_word_t cond;

    assign cond = {2'h0, error_in, 1'h0, relay_closed_in, remote_state_in,
                   4'h0, awaiting_trigger_flag_in, scanning_in, 4'h0};

    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    chk_live_read: assert property (
        read_sel_in == 2'h0 |=> read_data_out == $past(cond))
        else $error("live read wrong");
    chk_unused_zero: assert property (
        (read_data_out & ~16'h2c30) == 16'h0000)
        else $error("unused bit set");
    chk_event_keep: assert property (
        read_sel_in == 2'h1 && !$past(reset_in)
        |=> (read_data_out & $past(cond, 2)) == $past(cond, 2))
        else $error("event lost");
    chk_event_clear: assert property (
        clear_status_in && cond == 16'h0000 ##1 read_sel_in == 2'h1
        |=> read_data_out == 16'h0000)
        else $error("clear failed");
    chk_mask_write: assert property (
        mask_write_in ##1 read_sel_in == 2'h2 && !mask_write_in
        |=> read_data_out == ($past(mask_wdata_in, 2) & 16'h2c30))
        else $error("mask readback wrong");
    chk_mask_reset: assert property (
        read_sel_in == 2'h2 && $past(reset_in)
        |=> read_data_out == 16'h0000)
        else $error("mask not zero");
    chk_sum_clear: assert property (
        mask_write_in && (mask_wdata_in & 16'h2c30) == 16'h0000
        ##1 !mask_write_in |=> !summary_out)
        else $error("summary stuck");
    chk_sum_set: assert property (
        mask_write_in && mask_wdata_in[10]
        ##1 remote_state_in && !mask_write_in |=> ##1 summary_out)
        else $error("no summary");
endmodule // osrg_assertions

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import osrg_pkg::*;
    logic       mclk_in                  = 1'b0;
    logic       reset_in                 = 1'b1;
    logic       error_in                 = 1'b0;
    logic       relay_closed_in          = 1'b0;
    logic       remote_state_in          = 1'b0;
    logic       awaiting_trigger_flag_in = 1'b0;
    logic       scanning_in              = 1'b0;
    logic       clear_status_in          = 1'b0;
    logic       mask_write_in            = 1'b0;
    logic       summary_out;
    osrg_word_t mask_wdata_in            = 16'h0000;
    osrg_word_t read_data_out;
    osrg_sel_t  read_sel_in              = 2'h2;
    int         n_errors                 = 0;
    int         n_tests                  = 0;

    osrg_top i_dut (.*);

    initial begin
        forever begin
            #2.5 mclk_in = ~mclk_in;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic chk(input string s, input osrg_word_t seen,
                       input osrg_word_t exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s exp %h seen %h", s, exp, seen);
        end
    endtask

    task automatic rd(input string s, input osrg_sel_t sel,
                      input osrg_word_t exp);
        read_sel_in = sel;
        cyc(2);
        chk(s, read_data_out, exp);
    endtask

    task automatic wr(input osrg_word_t d);
        mask_write_in = 1'b1;
        mask_wdata_in = d;
        cyc(1);
        mask_write_in = 1'b0;
    endtask

    task automatic clr;
        clear_status_in = 1'b1;
        cyc(1);
        clear_status_in = 1'b0;
    endtask

    task automatic t_reset;
        rd("mask_reset", 2'h2, 16'h0000);
        rd("spare_sel", 2'h3, 16'h0000);
    endtask

    task automatic t_live;
        remote_state_in = 1'b1;
        rd("live_remote", 2'h0, 16'h0400);
        rd("event_remote", 2'h1, 16'h0400);
        error_in = 1'b1;
        relay_closed_in = 1'b1;
        awaiting_trigger_flag_in = 1'b1;
        scanning_in = 1'b1;
        rd("live_all", 2'h0, 16'h2c30);
        error_in = 1'b0;
        relay_closed_in = 1'b0;
        remote_state_in = 1'b0;
        awaiting_trigger_flag_in = 1'b0;
        scanning_in = 1'b0;
        rd("live_none", 2'h0, 16'h0000);
        rd("event_kept", 2'h1, 16'h2c30);
    endtask

    task automatic t_clear;
        clr;
        rd("event_clear", 2'h1, 16'h0000);
        scanning_in = 1'b1;
        clr;
        rd("event_set_wins", 2'h1, 16'h0010);
        scanning_in = 1'b0;
        clr;
        rd("event_clear2", 2'h1, 16'h0000);
    endtask

    task automatic t_mask;
        remote_state_in = 1'b1;
        wr(16'hffff);
        rd("mask_used", 2'h2, 16'h2c30);
        chk("summary_on", {15'h0000, summary_out}, 16'h0001);
        wr(16'h0410);
        rd("mask_value", 2'h2, 16'h0410);
        chk("summary_kept", {15'h0000, summary_out}, 16'h0001);
        wr(16'h0010);
        cyc(2);
        chk("summary_other", {15'h0000, summary_out}, 16'h0000);
        wr(16'h0000);
        cyc(2);
        chk("summary_off", {15'h0000, summary_out}, 16'h0000);
    endtask

    task automatic test_done;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under a hundred cycles
    initial begin
        #2000;
        n_errors++;
        test_done;
    end

    initial begin
        cyc(5);
        reset_in = 1'b0;
        t_reset;
        t_live;
        t_clear;
        t_mask;
        test_done;
    end
endmodule // tb_top
bind osrg_top osrg_assertions i_chk (.*);
